// *** hdl/pgr_clock_router.sv ***
// Top of the clock routing block: eight PLLs, global nets and register slave.
//
// Operation
// - Four north PLLs feed the four fast global nets and four south PLLs the four array nets.
// - All eight global nets reach the tile clock cluster on the same clock edge.
// - Each output may drive a global net or a core routed net; only output a may also drive the neighbour's reference.
// - Both outputs go low once the reference input has held a constant level for IDLE_CNT cycles.
// - A north PLL's first fast net is its own and its second belongs to its neighbour.
// - Low power-down control sleeps a PLL and raising it restarts it until lock returns.
`timescale 1ns/10ps
module pgr_clock_router #(
    parameter int LOCK_CNT = pgr_pkg::LOCK_CYCLES,
    parameter int IDLE_CNT = pgr_pkg::REF_IDLE_CYCLES
) (
    // Clock and reset.
    input  wire logic                          i_clock,
    input  wire logic                          i_rstn,
    // Avalon-MM slave.
    input  wire logic [5:0]                    i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [31:0]                   i_avs_writedata,
    input  wire logic [3:0]                    i_avs_byteenable,
    output logic [31:0]                        o_avs_readdata,
    output logic                               o_avs_waitrequest,
    // Reference clock pins.
    input  wire logic [pgr_pkg::PLL_COUNT-1:0] i_reference_clock_input,
    // Global nets, tile cluster and core routed nets.
    output logic [pgr_pkg::PLL_COUNT-1:0]      o_global_net,
    output logic [pgr_pkg::PLL_COUNT-1:0]      o_tile_clock_cluster,
    output logic [pgr_pkg::PLL_COUNT-1:0]      o_routed_net
);
    import pgr_pkg::*;

    pgr_cfg_s                 cfg_ff     [PLL_COUNT];
    pgr_cfg_s                 nxt_cfg    [PLL_COUNT];
    pgr_pll_s                 pll        [PLL_COUNT];
    logic [PLL_COUNT-1:0]     legal;
    logic [PLL_COUNT-1:0]     ref_in;
    logic [PLL_COUNT-1:0]     net_ff, nxt_net;
    logic [PLL_COUNT-1:0]     tile_ff, nxt_tile;
    logic [PLL_COUNT-1:0]     routed_ff, nxt_routed;
    logic [PLL_COUNT-1:0]     pin_meta_ff, nxt_pin_meta;
    logic [PLL_COUNT-1:0]     pin_sync_ff, nxt_pin_sync;
    logic                     wait_ff, nxt_wait;
    logic [31:0]              rdata_ff, nxt_rdata;
    logic                     req;
    logic [2:0]               sel;

    // Pairings that a PLL may use; anything else leaves both outputs unrouted.
    function automatic logic check_pairing(input pgr_cfg_s c, input logic north);
        logic ga;
        logic gb;
        logic ok;
        ga = c.dest_a[DEST_PRIMARY] | c.dest_a[DEST_ADJACENT];
        gb = c.dest_b[DEST_PRIMARY] | c.dest_b[DEST_ADJACENT];
        ok = 1'b1;
        if (c.dest_a[DEST_ROUTED] && c.dest_b[DEST_ROUTED]) begin
            ok = 1'b0;
        end
        if ((c.dest_a[1:0] & c.dest_b[1:0]) != 2'h0) begin
            ok = 1'b0;
        end
        if (c.dest_a[DEST_PRIMARY] && c.dest_a[DEST_ROUTED] && c.dest_b != 4'h0) begin
            ok = 1'b0;
        end
        if (!north && (c.dest_a[DEST_ROUTED] || c.dest_b[DEST_ROUTED]) && (ga || gb)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : check_pairing

    generate
        for (genvar p = 0; p < PLL_COUNT; p++) begin : g_pll
            assign ref_in[p] = cfg_ff[p].ref_from_neighbor
                ? (pll[p ^ 1].pll_output_a & cfg_ff[p ^ 1].dest_a[DEST_NEIGHBOR] & legal[p ^ 1])
                : pin_sync_ff[p];
            assign legal[p]  = check_pairing(cfg_ff[p], (p < GROUP_SIZE));

            pgr_pll_unit #(
                .LOCK_CNT (LOCK_CNT),
                .IDLE_CNT (IDLE_CNT)
            ) u_pll (
                .i_clock                 (i_clock),
                .i_rstn                  (i_rstn),
                .i_reference_clock_input (ref_in[p]),
                .i_pll_sleep_n           (cfg_ff[p].pll_sleep_n),
                .o_pll                   (pll[p])
            );

            always_comb begin
                nxt_net[p] = legal[p] &
                    ((pll[p].pll_output_a & cfg_ff[p].dest_a[DEST_PRIMARY]) |
                     (pll[p].pll_output_b & cfg_ff[p].dest_b[DEST_PRIMARY]));
                nxt_net[p] = nxt_net[p] | (legal[p ^ 1] & ~cfg_ff[p].dest_a[DEST_PRIMARY] &
                    ~cfg_ff[p].dest_b[DEST_PRIMARY] &
                    ((pll[p ^ 1].pll_output_a & cfg_ff[p ^ 1].dest_a[DEST_ADJACENT]) |
                     (pll[p ^ 1].pll_output_b & cfg_ff[p ^ 1].dest_b[DEST_ADJACENT])));
                nxt_routed[p] = legal[p] &
                    ((pll[p].pll_output_a & cfg_ff[p].dest_a[DEST_ROUTED]) |
                     (pll[p].pll_output_b & cfg_ff[p].dest_b[DEST_ROUTED]));
                nxt_cfg[p] = cfg_ff[p];
                // A write lands only on the edge that completes the transfer.
                if (i_avs_write && !wait_ff && i_avs_address[5] == CFG_BASE[5]
                    && i_avs_address[4:2] == 3'(p)) begin
                    if (i_avs_byteenable[0]) begin
                        nxt_cfg[p][7:0] = i_avs_writedata[7:0];
                    end
                    if (i_avs_byteenable[1]) begin
                        nxt_cfg[p][9:8] = i_avs_writedata[9:8];
                    end
                end
            end

            always_ff @(posedge i_clock or negedge i_rstn) begin
                if (!i_rstn) begin
                    cfg_ff[p] <= CFG_RESET;
                end else begin
                    cfg_ff[p] <= nxt_cfg[p];
                end
            end
        end
    endgenerate

    // Bus answer: every request sees exactly one wait cycle.
    always_comb begin
        req       = i_avs_read | i_avs_write;
        sel       = i_avs_address[4:2];
        nxt_wait  = ~(req & wait_ff);
        nxt_rdata = rdata_ff;
        // Pins pass two flops before the neighbour mux may read them.
        nxt_pin_meta = i_reference_clock_input;
        nxt_pin_sync = pin_meta_ff;
        nxt_tile  = nxt_net;
        if (i_avs_read && wait_ff) begin
            nxt_rdata = 32'h0000_0000;
            if (i_avs_address[5] == CFG_BASE[5]) begin
                nxt_rdata[9:0] = cfg_ff[sel];
            end else begin
                nxt_rdata[ST_LOCKED]  = pll[sel].locked;
                nxt_rdata[ST_REF_ON]  = pll[sel].ref_active;
                nxt_rdata[ST_ILLEGAL] = ~legal[sel];
                nxt_rdata[ST_OUT_A]   = pll[sel].pll_output_a;
                nxt_rdata[ST_OUT_B]   = pll[sel].pll_output_b;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_ff   <= 1'b1;
            rdata_ff  <= 32'h0000_0000;
            net_ff    <= '0;
            tile_ff   <= '0;
            routed_ff <= '0;
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            wait_ff   <= nxt_wait;
            rdata_ff  <= nxt_rdata;
            net_ff    <= nxt_net;
            tile_ff   <= nxt_tile;
            routed_ff <= nxt_routed;
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
        end
    end

    assign o_avs_waitrequest    = wait_ff;
    assign o_avs_readdata       = rdata_ff;
    assign o_global_net         = net_ff;
    assign o_tile_clock_cluster = tile_ff;
    assign o_routed_net         = routed_ff;

endmodule : pgr_clock_router

// *** common/pgr_pkg.sv ***
// Shared constants and types for the clock routing block.
package pgr_pkg;

    // Clock rate and timing.
    localparam int CLOCK_KHZ       = 25000;
    localparam int LOCK_TIME_NS    = 20000;
    localparam int LOCK_CYCLES     = (LOCK_TIME_NS * (CLOCK_KHZ / 1000) + 999) / 1000;
    localparam int REF_IDLE_NS     = 400;
    localparam int REF_IDLE_CYCLES = (REF_IDLE_NS * (CLOCK_KHZ / 1000)) / 1000;

    // Structure.
    localparam int PLL_COUNT   = 8;
    localparam int GROUP_SIZE  = 4;

    // Register map, byte addresses.
    localparam logic [5:0] CFG_BASE    = 6'h00;
    localparam logic [5:0] STATUS_BASE = 6'h20;

    // Destination bits of one output.
    localparam int DEST_PRIMARY  = 0;
    localparam int DEST_ADJACENT = 1;
    localparam int DEST_ROUTED   = 2;
    localparam int DEST_NEIGHBOR = 3;

    // Status bit positions.
    localparam int ST_LOCKED  = 0;
    localparam int ST_REF_ON  = 1;
    localparam int ST_ILLEGAL = 2;
    localparam int ST_OUT_A   = 3;
    localparam int ST_OUT_B   = 4;

    localparam logic [9:0] CFG_RESET = 10'h000;

    typedef struct packed {
        logic       ref_from_neighbor;
        logic       pll_sleep_n;
        logic [3:0] dest_b;
        logic [3:0] dest_a;
    } pgr_cfg_s;

    typedef struct packed {
        logic pll_output_a;
        logic pll_output_b;
        logic locked;
        logic ref_active;
    } pgr_pll_s;

endpackage : pgr_pkg

// *** hdl/pgr_pll_unit.sv ***
// One PLL: reference watch, power down, lock wait and output gating.
`timescale 1ns/10ps
module pgr_pll_unit #(
    parameter int LOCK_CNT = pgr_pkg::LOCK_CYCLES,
    parameter int IDLE_CNT = pgr_pkg::REF_IDLE_CYCLES
) (
    // Clock and reset.
    input  wire logic            i_clock,
    input  wire logic            i_rstn,
    // Reference and control.
    input  wire logic            i_reference_clock_input,
    input  wire logic            i_pll_sleep_n,
    // Outputs.
    output pgr_pkg::pgr_pll_s    o_pll
);
    import pgr_pkg::*;

    typedef enum logic [1:0] {ST_SLEEP, ST_LOCKING, ST_RUN} pgr_pll_e;

    pgr_pll_e    state_ff, nxt_state;
    logic [2:0]  ref_sync_ff, nxt_ref_sync;
    logic [15:0] idle_ff, nxt_idle;
    logic [15:0] lock_ff, nxt_lock;
    pgr_pll_s    pll_ff, nxt_pll;
    logic        ref_edge;
    logic        ref_active;

    always_comb begin
        nxt_ref_sync = {ref_sync_ff[1:0], i_reference_clock_input};
        // Edges are taken only from the second and third stages.
        ref_edge     = ref_sync_ff[1] ^ ref_sync_ff[2];
        ref_active   = (idle_ff < 16'(IDLE_CNT));
        nxt_idle     = ref_edge ? 16'h0000 : (ref_active ? idle_ff + 16'h0001 : idle_ff);
        nxt_state    = state_ff;
        nxt_lock     = lock_ff;
        case (state_ff)
            ST_SLEEP: begin
                nxt_lock = 16'h0000;
                if (i_pll_sleep_n) begin
                    nxt_state = ST_LOCKING;
                end
            end
            ST_LOCKING: begin
                if (!i_pll_sleep_n) begin
                    nxt_state = ST_SLEEP;
                end else if (!ref_active) begin
                    nxt_lock = 16'h0000;
                end else if (lock_ff >= 16'(LOCK_CNT - 1)) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_lock = lock_ff + 16'h0001;
                end
            end
            ST_RUN: begin
                if (!i_pll_sleep_n) begin
                    nxt_state = ST_SLEEP;
                end else if (!ref_active) begin
                    // A stopped reference means lock must be regained afterwards.
                    nxt_state = ST_LOCKING;
                    nxt_lock  = 16'h0000;
                end
            end
            default: begin
                nxt_state = ST_SLEEP;
            end
        endcase
        nxt_pll.locked     = (nxt_state == ST_RUN);
        nxt_pll.ref_active = ref_active;
        if (state_ff == ST_RUN && ref_active && i_pll_sleep_n) begin
            nxt_pll.pll_output_a = ref_sync_ff[1];
            nxt_pll.pll_output_b = (ref_sync_ff[1] & ~ref_sync_ff[2]) ^ pll_ff.pll_output_b;
        end else begin
            nxt_pll.pll_output_a = 1'b0;
            nxt_pll.pll_output_b = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff    <= ST_SLEEP;
            ref_sync_ff <= 3'h0;
            idle_ff     <= 16'(IDLE_CNT);
            lock_ff     <= 16'h0000;
            pll_ff      <= '0;
        end else begin
            state_ff    <= nxt_state;
            ref_sync_ff <= nxt_ref_sync;
            idle_ff     <= nxt_idle;
            lock_ff     <= nxt_lock;
            pll_ff      <= nxt_pll;
        end
    end

    assign o_pll = pll_ff;

endmodule : pgr_pll_unit

// *** tb/pgr_props.sv ***
// Port checker for the clock routing block.
`timescale 1ns/10ps
module pgr_props #(
    parameter int LOCK_CNT = 8,
    parameter int IDLE_CNT = 10
) (
    // Clock, reset and bus.
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // Pins and nets.
    input wire logic [7:0]  i_reference_clock_input,
    input wire logic [7:0]  o_global_net,
    input wire logic [7:0]  o_tile_clock_cluster,
    input wire logic [7:0]  o_routed_net
);
    logic [7:0] ref_ff;
    int         qn_ff;
    int         qs_ff;
    // Quiet counters saturate so that a long idle reference cannot wrap them.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_ff <= 8'h00;
            qn_ff  <= 0;
            qs_ff  <= 0;
        end else begin
            ref_ff <= i_reference_clock_input;
            qn_ff  <= (ref_ff[3:0] != i_reference_clock_input[3:0]) ? 0 : qn_ff + (qn_ff < 999);
            qs_ff  <= (ref_ff[7:4] != i_reference_clock_input[7:4]) ? 0 : qs_ff + (qs_ff < 999);
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ans;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    wait_answer_a: assert property (s_req |=> s_ans) else $error("bus answer not one cycle");
    wait_idle_a: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("wait dropped without a request");
    read_hold_a: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read)
        && !o_avs_waitrequest) else $error("read data moved outside a read");
    reset_bus_a: assert property ($rose(i_rstn) |-> o_avs_waitrequest
        && o_avs_readdata == 32'h0) else $error("bus not idle after reset");
    tile_match_a: assert property (o_tile_clock_cluster == o_global_net)
        else $error("tile cluster differs from global nets");
    north_group_a: assert property (qn_ff > IDLE_CNT + 12 |-> o_global_net[3:0] == 4'h0)
        else $error("fast net active without north reference");
    south_group_a: assert property (qs_ff > IDLE_CNT + 12 |-> o_global_net[7:4] == 4'h0)
        else $error("array net active without south reference");
    ref_quiet_a: assert property (qn_ff > IDLE_CNT + 12 && qs_ff > IDLE_CNT + 12
        |-> o_global_net == 8'h00 && o_routed_net == 8'h00) else $error("net active on idle ref");
    sleep_quiet_a: assert property ($rose(i_rstn) |-> (o_global_net == 8'h00
        && o_routed_net == 8'h00) [*8]) else $error("net active while asleep");
endmodule : pgr_props

// *** tb/pgr_core_model.sv ***
// Core logic model: records which global and routed nets carried rising edges.
`timescale 1ns/10ps
module pgr_core_model (
    // Clock, reset and clear.
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_clear,
    // Nets seen by the core.
    input  wire logic [7:0] i_global_net,
    input  wire logic [7:0] i_routed_net,
    output logic [15:0]     o_seen
);
    logic [15:0] prev_ff;
    logic [15:0] seen_ff;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_ff <= 16'h0000;
            seen_ff <= 16'h0000;
        end else begin
            prev_ff <= {i_routed_net, i_global_net};
            seen_ff <= i_clear ? 16'h0000 : seen_ff | ({i_routed_net, i_global_net} & ~prev_ff);
        end
    end
    assign o_seen = seen_ff;
endmodule : pgr_core_model

// *** tb/tb_pgr_clock_router.sv ***
// Testbench for the clock routing block.
`timescale 1ns/10ps
module tb_pgr_clock_router;
    import pgr_pkg::*;
    localparam int LK = 8;
    localparam int IC = 10;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic [5:0]  adr   = 6'h00;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdat  = 32'h0;
    logic [7:0]  refc  = 8'h00;
    logic [7:0]  run   = 8'h11;
    logic [1:0]  ph    = 2'h0;
    logic        clr   = 1'b0;
    logic [31:0] rdat;
    logic        wreq;
    logic [7:0]  gnet;
    logic [7:0]  tile;
    logic [7:0]  rnet;
    logic [15:0] seen;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          t0;
    pgr_clock_router #(.LOCK_CNT(LK), .IDLE_CNT(IC)) u_pgr_clock_router (
        .i_clock(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_reference_clock_input(refc),
        .o_global_net(gnet), .o_tile_clock_cluster(tile), .o_routed_net(rnet));
    pgr_core_model u_pgr_core_model (.i_clock(clk), .i_rstn(rstn), .i_clear(clr),
        .i_global_net(gnet), .i_routed_net(rnet), .o_seen(seen));
    initial forever #20 clk = ~clk;
    // The reference toggles every four cycles, well inside the idle limit.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ph <= ph + 2'h1;
        if (ph == 2'h3) refc <= refc ^ run;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_lock(input logic [2:0] p);
        logic [31:0] q;
        for (int n = 0; n < 40; n++) begin
            xfer(1'b0, {1'b1, p, 2'b00}, 32'h0, q);
            if (q[ST_LOCKED] === 1'b1) break;
        end
        chk("locked", 32'h1, {31'h0, q[ST_LOCKED]});
    endtask : wait_lock
    task automatic look(input logic [15:0] e);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (40) @(posedge clk);
        chk("nets seen", {16'h0, e}, {16'h0, seen});
    endtask : look
    task automatic row(input logic [2:0] p, input logic [9:0] w, input logic il,
                       input logic [15:0] e);
        logic [31:0] q;
        xfer(1'b1, {1'b0, p, 2'b00}, {22'h0, w}, q);
        wait_lock(p);
        look(e);
        xfer(1'b0, {1'b1, p, 2'b00}, 32'h0, q);
        chk("illegal flag", {31'h0, il}, {31'h0, q[ST_ILLEGAL]});
    endtask : row
    task automatic t_reset;
        logic [31:0] q;
        xfer(1'b0, CFG_BASE, 32'h0, q);
        chk("cfg reset", {22'h0, CFG_RESET}, q);
        xfer(1'b0, STATUS_BASE, 32'h0, q);
        chk("status reset", 32'h0, q);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_rows;
        logic [31:0] q;
        row(3'd4, 10'h101, 1'b0, 16'h0010);
        row(3'd4, 10'h141, 1'b1, 16'h0000);
        run <= 8'h01;
        row(3'd0, 10'h101, 1'b0, 16'h0001);
        row(3'd0, 10'h102, 1'b0, 16'h0002);
        row(3'd0, 10'h112, 1'b0, 16'h0003);
        row(3'd0, 10'h141, 1'b0, 16'h0101);
        row(3'd0, 10'h144, 1'b1, 16'h0000);
        row(3'd0, 10'h111, 1'b1, 16'h0000);
        row(3'd0, 10'h125, 1'b1, 16'h0000);
        // PLL0 output a feeds PLL1's reference; PLL1 then drives its own net.
        xfer(1'b1, {1'b0, 3'd0, 2'b00}, 32'h109, q);
        row(3'd1, 10'h301, 1'b0, 16'h0003);
        $display("t_rows done");
    endtask : t_rows
    task automatic t_stop;
        logic [31:0] q;
        xfer(1'b1, CFG_BASE, 32'h101, q);
        for (int lvl = 0; lvl < 2; lvl++) begin
            run <= 8'h01;
            wait_lock(3'd0);
            // Stop only where no toggle is due, so the pin rests at the wanted level.
            do @(posedge clk); while (refc[0] !== lvl[0] || ph == 2'h3);
            run <= 8'h00;
            repeat (IC + 20) @(posedge clk);
            look(16'h0000);
        end
        $display("t_stop done");
    endtask : t_stop
    task automatic t_sleep;
        logic [31:0] q;
        run <= 8'h01;
        wait_lock(3'd0);
        xfer(1'b1, CFG_BASE, 32'h001, q);
        repeat (4) @(posedge clk);
        look(16'h0000);
        xfer(1'b0, STATUS_BASE, 32'h0, q);
        chk("asleep unlocked", 32'h0, {31'h0, q[ST_LOCKED]});
        t0 = cyc;
        xfer(1'b1, CFG_BASE, 32'h101, q);
        wait_lock(3'd0);
        chk("lock wait", 32'h1, {31'h0, (cyc - t0) >= LK});
        look(16'h0001);
        $display("t_sleep done");
    endtask : t_sleep
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_rows();
        t_stop();
        t_sleep();
        results();
    end
endmodule : tb_pgr_clock_router
bind pgr_clock_router pgr_props #(.LOCK_CNT(LOCK_CNT), .IDLE_CNT(IDLE_CNT)) u_pgr_props (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_reference_clock_input(i_reference_clock_input), .o_global_net(o_global_net),
    .o_tile_clock_cluster(o_tile_clock_cluster), .o_routed_net(o_routed_net));
